//--- twm_regs.svh
// Constants for the two-wire master controller.
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH
// =====================================================================
// Field widths and reset values
`define TWM_INTERNAL_ADDRESS_VALUE_SZ_W 2
`define TWM_DIV_W 8
`define TWM_PRESC_W 3
`define TWM_FIFO_DEPTH 32
`define TWM_RST_CLK_LOW_DIV 8'h10
`define TWM_RST_CLK_HIGH_DIV 8'h10
`define TWM_RST_PRESC 3'h0
// =====================================================================
// Timing: fastest legal bus clock is 400 kbit/s, so each half needs 1250 ns.
`define TWM_CLK_PERIOD_NS 10
`define TWM_MIN_HALF_NS 1250
`define TWM_MIN_HALF_CYC ((`TWM_MIN_HALF_NS + `TWM_CLK_PERIOD_NS - 1) / `TWM_CLK_PERIOD_NS)
`endif

//--- twm_pkg.sv
// Types for the two-wire master controller.
package twm_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_WAIT, ST_RSTART, ST_STOP, ST_DONE
  } twm_state_t;
  typedef enum logic [1:0] {
    PH_ADDR, PH_INTERNAL_ADDRESS_VALUE, PH_WDATA, PH_RDATA
  } twm_phase_t;
endpackage

//--- twm_fifo.sv
// Receive data FIFO of the two-wire master controller.
`timescale 1ns/1ps
module twm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire pushEn = inValid && inReady;
  wire popEn = outValid && outReady;
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  always_ff @(posedge clk) begin
    if (pushEn) begin
      mem[wrPtr_q] <= inData;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (pushEn) wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (popEn) rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW + 1)'(pushEn) - (AW + 1)'(popEn);
    end
  end
endmodule

//--- twm_clkgen.sv
// Bus clock tick generator: prescaler plus low and high dividers.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_clkgen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic sclHigh,
  input wire logic [`TWM_PRESC_W-1:0] prescale,
  input wire logic [`TWM_DIV_W-1:0] lowDiv,
  input wire logic [`TWM_DIV_W-1:0] highDiv,
  output logic tick
);
  // =====================================================================
  // Half period length
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  wire [19:0] rawLow = (20'({lowDiv, 1'b0}) + 20'h00004) << prescale;
  wire [19:0] rawHigh = (20'({highDiv, 1'b0}) + 20'h00004) << prescale;
  wire [19:0] selHalf = sclHigh ? rawHigh : rawLow;
  // Never shorter than the 400 kbit/s half period whatever the dividers say.
  wire [19:0] halfLen = (selHalf < 20'(`TWM_MIN_HALF_CYC)) ? 20'(`TWM_MIN_HALF_CYC) : selHalf;
  wire hit = run && (cnt_q + 20'h00001 >= halfLen);
  assign cnt_d = (!run || hit) ? 20'h00000 : cnt_q + 20'h00001;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 20'h00000;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= hit;
    end
  end
endmodule

//--- twm_master.sv
// Two-wire bus master controller top level.
`timescale 1ns/1ps
`include "twm_regs.svh"
// Function
// - Bytes are eight bits, MSB first, each followed by an acknowledge bit.
// - START is data falling with clock high; STOP is data rising with clock high.
// - Both lines are only pulled low or released, never driven high.
// - A transmit write starts START, 7-bit address, direction bit 0.
// - On the ninth pulse release data, sample it, flag no-acknowledge if high.
// - Each status flag raises the interrupt when its enable bit is set.
// - After acknowledge, load holding data to shifter; set transmit-ready until next write (here set only at an acknowledge with no unsent byte held).
// - In a write, hold the clock low until new transmit data arrives.
// - STOP comes only from the stop command or a no-acknowledge; otherwise clock stays stretched.
// - Start command in receive mode sends START, address, direction 1, checks acknowledge.
// - Acknowledge each received byte except the last, which is followed by STOP.
// - Receive-ready sets when a byte lands; reading the holding register clears it (here only once that read empties the 32-entry receive FIFO).
// - Read with internal address first writes address bytes, then repeated START.
// - Send zero to three internal address bytes per size field.
module twm_master (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic masterEnableCmd,
  input wire logic slaveDisableCmd,
  input wire logic startCmd,
  input wire logic stopCmd,
  input wire logic readDirectionBit,
  input wire logic [6:0] targetDeviceAddress,
  input wire logic [`TWM_INTERNAL_ADDRESS_VALUE_SZ_W-1:0] internalAddressSize,
  input wire logic [23:0] internalAddressValue,
  input wire logic [`TWM_PRESC_W-1:0] clockPrescaleField,
  input wire logic [`TWM_DIV_W-1:0] clockLowDivider,
  input wire logic [`TWM_DIV_W-1:0] clockHighDivider,
  input wire logic [7:0] txHoldWrData,
  input wire logic txHoldWrite,
  output logic [7:0] rxHoldData,
  input wire logic rxHoldRead,
  input wire logic [2:0] intEnable,
  output logic noAcknowledgeFlag,
  output logic transmitReadyFlag,
  output logic receiveReadyFlag,
  output logic irq,
  output logic busy,
  input wire logic serialDataLineIn,
  output logic serialDataLineOut,
  output logic serialDataLineOe,
  input wire logic serialClockLineIn,
  output logic serialClockLineOut,
  output logic serialClockLineOe
);
  // =====================================================================
  // Pin synchronisers
  logic [1:0] sdaSync_q;
  logic [1:0] sclSync_q;
  wire sdaIn = sdaSync_q[1];
  wire sclIn = sclSync_q[1];

  // =====================================================================
  // State
  twm_pkg::twm_state_t state_q;
  twm_pkg::twm_phase_t phase_q;
  logic mode_q;
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic [1:0] iadrLeft_q;
  logic readAfter_q;
  logic stopPend_q;
  logic txPend_q;
  logic [7:0] txHold_q;
  logic sclDrvLow_q;
  logic sdaDrvLow_q;
  logic [1:0] sub_q;
  logic [7:0] rxPushData_q;
  logic rxPush_q;
  logic enabled_q;

  // =====================================================================
  // Clock tick and receive FIFO
  logic tick;
  logic sclHighPhase;
  logic runClk;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  assign sclHighPhase = !sclDrvLow_q;
  assign runClk = (state_q != twm_pkg::ST_IDLE) && (state_q != twm_pkg::ST_WAIT);

  twm_clkgen uClk (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(runClk),
    .sclHigh(sclHighPhase),
    .prescale(clockPrescaleField),
    .lowDiv(clockLowDivider),
    .highDiv(clockHighDivider),
    .tick(tick)
  );

  twm_fifo #(.WIDTH(8), .DEPTH(`TWM_FIFO_DEPTH)) uFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(rxPush_q),
    .inReady(fifoInReady),
    .inData(rxPushData_q),
    .outValid(fifoOutValid),
    .outReady(rxHoldRead),
    .outData(fifoOutData)
  );

  // =====================================================================
  // Decoded helpers
  function automatic logic [7:0] iadrByte(input logic [23:0] v, input logic [1:0] idx);
    iadrByte = (idx == 2'h3) ? v[23:16] : (idx == 2'h2) ? v[15:8] : v[7:0];
  endfunction

  // Clock stretching by a slave: a released clock that still reads low pauses us.
  wire sclStretched = !sclDrvLow_q && !sclIn;
  wire step = tick && !sclStretched;
  wire lastBit = (bitCnt_q == 3'h0);
  wire isRead = (phase_q == twm_pkg::PH_RDATA);
  wire [7:0] addrByteW = {targetDeviceAddress, 1'b0};
  wire [7:0] addrByteR = {targetDeviceAddress, 1'b1};
  wire needIadr = (internalAddressSize != 2'h0);
  wire [7:0] firstByte = (needIadr || !readDirectionBit) ? addrByteW : addrByteR;
  // The receive FIFO stalls reception: no new read byte starts while it is full.
  wire rxRoom = fifoInReady && !rxPush_q;
  wire kickWrite = enabled_q && !readDirectionBit && txHoldWrite;
  wire kickRead = enabled_q && readDirectionBit && startCmd;

  // Receive outputs are registered, so they trail the FIFO head by one cycle.

  // =====================================================================
  // Pins and bus synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaSync_q <= 2'h3;
      sclSync_q <= 2'h3;
    end else begin
      sdaSync_q <= {sdaSync_q[0], serialDataLineIn};
      sclSync_q <= {sclSync_q[0], serialClockLineIn};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serialDataLineOut <= 1'b0;
      serialClockLineOut <= 1'b0;
      serialDataLineOe <= 1'b0;
      serialClockLineOe <= 1'b0;
      busy <= 1'b0;
      irq <= 1'b0;
      rxHoldData <= 8'h00;
      receiveReadyFlag <= 1'b0;
    end else begin
      serialDataLineOut <= 1'b0;
      serialClockLineOut <= 1'b0;
      serialDataLineOe <= sdaDrvLow_q;
      serialClockLineOe <= sclDrvLow_q;
      busy <= (state_q != twm_pkg::ST_IDLE);
      rxHoldData <= fifoOutData;
      receiveReadyFlag <= fifoOutValid;
      irq <= (intEnable[0] && noAcknowledgeFlag) || (intEnable[1] && transmitReadyFlag) ||
             (intEnable[2] && receiveReadyFlag);
    end
  end

  // =====================================================================
  // Software side holding register and commands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enabled_q <= 1'b0;
      txHold_q <= 8'h00;
      txPend_q <= 1'b0;
      stopPend_q <= 1'b0;
    end else begin
      if (masterEnableCmd && slaveDisableCmd) enabled_q <= 1'b1;
      if (txHoldWrite) txHold_q <= txHoldWrData;
      if (txHoldWrite) begin
        txPend_q <= 1'b1;
      end else if (state_q == twm_pkg::ST_BIT && phase_q == twm_pkg::PH_WDATA && sub_q == 2'h0
                   && bitCnt_q == 3'h7 && step) begin
        txPend_q <= 1'b0;
      end
      if (stopCmd) begin
        stopPend_q <= 1'b1;
      end else if (state_q == twm_pkg::ST_DONE) begin
        stopPend_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Bus sequencer. Each bit is four quarter steps: 0 clock low set data, 1 release clock,
  // 2 sample, 3 pull clock low.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= twm_pkg::ST_IDLE;
      phase_q <= twm_pkg::PH_ADDR;
      mode_q <= 1'b0;
      shift_q <= 8'h00;
      bitCnt_q <= 3'h7;
      iadrLeft_q <= 2'h0;
      readAfter_q <= 1'b0;
      sclDrvLow_q <= 1'b0;
      sdaDrvLow_q <= 1'b0;
      sub_q <= 2'h0;
      noAcknowledgeFlag <= 1'b0;
      transmitReadyFlag <= 1'b1;
      rxPush_q <= 1'b0;
      rxPushData_q <= 8'h00;
    end else begin
      rxPush_q <= 1'b0;
      if (txHoldWrite && enabled_q) transmitReadyFlag <= 1'b0;
      unique case (state_q)
        twm_pkg::ST_IDLE: begin
          sclDrvLow_q <= 1'b0;
          sdaDrvLow_q <= 1'b0;
          if (kickWrite || kickRead) begin
            noAcknowledgeFlag <= 1'b0;
            mode_q <= readDirectionBit;
            readAfter_q <= readDirectionBit && needIadr;
            iadrLeft_q <= internalAddressSize;
            shift_q <= firstByte;
            phase_q <= twm_pkg::PH_ADDR;
            sub_q <= 2'h0;
            state_q <= twm_pkg::ST_START;
          end
        end
        twm_pkg::ST_START, twm_pkg::ST_RSTART: if (step) begin
          // Data falls while the clock is released high, then clock is pulled low.
          sub_q <= sub_q + 2'h1;
          if (sub_q == 2'h0) begin
            sdaDrvLow_q <= 1'b0;
            sclDrvLow_q <= 1'b0;
          end else if (sub_q == 2'h1) begin
            sdaDrvLow_q <= 1'b1;
          end else if (sub_q == 2'h2) begin
            sclDrvLow_q <= 1'b1;
          end else begin
            bitCnt_q <= 3'h7;
            state_q <= twm_pkg::ST_BIT;
          end
        end
        twm_pkg::ST_BIT: if (step) begin
          sub_q <= sub_q + 2'h1;
          if (sub_q == 2'h0) begin
            sclDrvLow_q <= 1'b1;
            sdaDrvLow_q <= isRead ? 1'b0 : !shift_q[7];
          end else if (sub_q == 2'h1) begin
            sclDrvLow_q <= 1'b0;
          end else if (sub_q == 2'h2) begin
            if (isRead) shift_q <= {shift_q[6:0], sdaIn};
          end else begin
            sclDrvLow_q <= 1'b1;
            if (!isRead) shift_q <= {shift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q - 3'h1;
            if (lastBit) state_q <= twm_pkg::ST_ACK;
          end
        end
        twm_pkg::ST_ACK: if (step) begin
          sub_q <= sub_q + 2'h1;
          if (sub_q == 2'h0) begin
            // Receiver acknowledges every byte but the one that ends with STOP.
            sdaDrvLow_q <= isRead ? !stopPend_q : 1'b0;
            if (isRead) begin
              rxPushData_q <= shift_q;
              rxPush_q <= 1'b1;
            end
          end else if (sub_q == 2'h1) begin
            sclDrvLow_q <= 1'b0;
          end else if (sub_q == 2'h2) begin
            if (!isRead && sdaIn) noAcknowledgeFlag <= 1'b1;
            // Ready only once the held byte is taken, so software cannot overwrite it unsent.
            if (!isRead && !sdaIn && !txPend_q) transmitReadyFlag <= 1'b1;
          end else begin
            sclDrvLow_q <= 1'b1;
            if (noAcknowledgeFlag) begin
              state_q <= twm_pkg::ST_STOP;
            end else if (isRead) begin
              state_q <= stopPend_q ? twm_pkg::ST_STOP : twm_pkg::ST_WAIT;
            end else if (iadrLeft_q != 2'h0) begin
              shift_q <= iadrByte(internalAddressValue, iadrLeft_q);
              iadrLeft_q <= iadrLeft_q - 2'h1;
              phase_q <= twm_pkg::PH_INTERNAL_ADDRESS_VALUE;
              bitCnt_q <= 3'h7;
              state_q <= twm_pkg::ST_BIT;
            end else if (readAfter_q) begin
              readAfter_q <= 1'b0;
              shift_q <= addrByteR;
              phase_q <= twm_pkg::PH_ADDR;
              state_q <= twm_pkg::ST_RSTART;
            end else if (phase_q == twm_pkg::PH_ADDR && mode_q) begin
              phase_q <= twm_pkg::PH_RDATA;
              state_q <= twm_pkg::ST_WAIT;
            end else begin
              phase_q <= twm_pkg::PH_WDATA;
              state_q <= twm_pkg::ST_WAIT;
            end
          end
        end
        twm_pkg::ST_WAIT: begin
          // Clock stays low here until transmit data or a stop request (write) or FIFO room (read) arrives.
          sclDrvLow_q <= 1'b1;
          sub_q <= 2'h0;
          bitCnt_q <= 3'h7;
          if (isRead) begin
            if (rxRoom) state_q <= twm_pkg::ST_BIT;
          end else if (txPend_q) begin
            shift_q <= txHold_q;
            state_q <= twm_pkg::ST_BIT;
          end else if (stopPend_q) begin
            state_q <= twm_pkg::ST_STOP;
          end
        end
        twm_pkg::ST_STOP: if (step) begin
          sub_q <= sub_q + 2'h1;
          if (sub_q == 2'h0) begin
            sdaDrvLow_q <= 1'b1;
          end else if (sub_q == 2'h1) begin
            sclDrvLow_q <= 1'b0;
          end else if (sub_q == 2'h2) begin
            sdaDrvLow_q <= 1'b0;
          end else begin
            state_q <= twm_pkg::ST_DONE;
          end
        end
        twm_pkg::ST_DONE: begin
          state_q <= twm_pkg::ST_IDLE;
        end
        default: begin
          state_q <= twm_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule

//--- twm_master_assertions.sv
// Port-level property checks for the two-wire master controller.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_master_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic masterEnableCmd,
  input wire logic slaveDisableCmd,
  input wire logic startCmd,
  input wire logic readDirectionBit,
  input wire logic txHoldWrite,
  input wire logic [2:0] intEnable,
  input wire logic noAcknowledgeFlag,
  input wire logic transmitReadyFlag,
  input wire logic receiveReadyFlag,
  input wire logic irq,
  input wire logic busy,
  input wire logic serialDataLineOut,
  input wire logic serialDataLineOe,
  input wire logic serialClockLineOut,
  input wire logic serialClockLineOe
);
  localparam int MinRun = `TWM_MIN_HALF_CYC - 1;
  logic enQ, sclPrevQ;
  logic [15:0] runQ;
  wire logic irqCause = |({receiveReadyFlag, transmitReadyFlag, noAcknowledgeFlag} & intEnable);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Helpers. The run length saturates so long idle spans never wrap.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enQ <= 1'b0;
      sclPrevQ <= 1'b0;
      runQ <= 16'h0000;
    end else begin
      enQ <= enQ | (masterEnableCmd & slaveDisableCmd);
      sclPrevQ <= serialClockLineOe;
      runQ <= (serialClockLineOe != sclPrevQ) ? 16'h0001 : runQ + 16'(runQ != 16'hFFFF);
    end
  end
  // ==========================================================
  // Properties
  AST_OPEN_DRAIN: assert property (!serialDataLineOut && !serialClockLineOut)
    else $error("bus pin driven high");
  AST_IDLE_FREE: assert property (!busy && !$past(busy) |-> !serialDataLineOe && !serialClockLineOe)
    else $error("bus not free while idle");
  AST_STOP_ENDS: assert property ($fell(serialDataLineOe) && !serialClockLineOe && !$past(serialClockLineOe) |-> ##[1:1000] !busy)
    else $error("data rose with clock high but transfer went on");
  AST_START_HOLD: assert property ($rose(serialDataLineOe) && !serialClockLineOe && !$past(serialClockLineOe) |-> busy ##1 serialDataLineOe [*8])
    else $error("start condition malformed");
  AST_CMD_BUSY: assert property (!busy && enQ && ((txHoldWrite && !readDirectionBit) || (startCmd && readDirectionBit)) |-> ##[1:3] busy)
    else $error("transfer request not taken");
  AST_NO_ENABLE: assert property (!enQ |-> !busy)
    else $error("busy before master enable");
  AST_TRANSMIT_READY_FLAG_HOLD: assert property (transmitReadyFlag && !txHoldWrite |=> transmitReadyFlag)
    else $error("transmit ready dropped without a write");
  AST_TRANSMIT_READY_FLAG_CLR: assert property (txHoldWrite && enQ |=> !transmitReadyFlag)
    else $error("transmit ready not cleared by write");
  AST_IRQ_FOLLOW: assert property (1'b1 |=> irq == $past(irqCause))
    else $error("interrupt does not follow enabled flags");
  AST_SCL_HALF: assert property (serialClockLineOe != sclPrevQ |-> runQ >= MinRun)
    else $error("clock half period too short");
  AST_NO_ACKNOWLEDGE_FLAG_STOP: assert property ($rose(noAcknowledgeFlag) |-> ##[1:1000] !busy)
    else $error("no stop after missing acknowledge");
  COV_NO_ACKNOWLEDGE_FLAG: cover property ($rose(noAcknowledgeFlag));
  COV_RX: cover property ($rose(receiveReadyFlag));
  COV_WR_BUSY: cover property (txHoldWrite && busy);
endmodule
bind twm_master twm_master_assertions u_twm_chk (.*);

//--- twm_slave_model.sv
// Behavioural slave on the two-wire bus: logs written bytes, returns a fixed byte on reads.
`timescale 1ns/1ps
module twm_slave_model (
  input wire logic sda,
  input wire logic scl,
  input wire logic ackAddr,
  input wire logic [7:0] rdData,
  output logic sdaPullLow
);
  logic [7:0] shiftQ;
  logic reading, addrPhase, mAckDue;
  logic [7:0] rxLog[$];
  int bitCnt, nStart, nStop, nBytes, nMAck, nMNack;
  initial begin
    sdaPullLow = 1'b0;
    reading = 1'b0;
    addrPhase = 1'b0;
    mAckDue = 1'b0;
    {bitCnt, nStart, nStop, nBytes, nMAck, nMNack} = '0;
  end
  always @(negedge sda) begin
    if (scl) begin
      nStart++;
      bitCnt = 0;
      addrPhase = 1'b1;
      reading = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1 && nStart > nStop) nStop++;
  end
  // Only the master may acknowledge a read byte, so the slave's own ack is never counted.
  always @(posedge scl) begin
    if (bitCnt < 8) shiftQ = {shiftQ[6:0], sda};
    else if (bitCnt == 8 && mAckDue) begin
      if (sda) nMNack++;
      else nMAck++;
      if (sda) reading = 1'b0;
    end
    bitCnt++;
  end
  always @(negedge scl) begin
    if (bitCnt == 8) begin
      if (!reading) rxLog.push_back(shiftQ);
      mAckDue = reading && !addrPhase;
      sdaPullLow = addrPhase ? ackAddr : !reading;
      if (addrPhase) reading = shiftQ[0];
      addrPhase = 1'b0;
    end else if (bitCnt == 9) begin
      nBytes++;
      bitCnt = 0;
      mAckDue = 1'b0;
      sdaPullLow = reading && !rdData[7];
    end else if (reading) sdaPullLow = !rdData[7 - bitCnt];
  end
endmodule

//--- twm_master_tb_top.sv
// Self-checking bench for the two-wire master controller.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_master_tb_top;
  logic clk, sys_rst, masterEnableCmd, slaveDisableCmd, startCmd, stopCmd, readDirectionBit;
  logic [6:0] targetDeviceAddress;
  logic [`TWM_INTERNAL_ADDRESS_VALUE_SZ_W-1:0] internalAddressSize;
  logic [23:0] internalAddressValue;
  logic [`TWM_PRESC_W-1:0] clockPrescaleField;
  logic [`TWM_DIV_W-1:0] clockLowDivider, clockHighDivider;
  logic [7:0] txHoldWrData, rxHoldData;
  logic [2:0] intEnable;
  logic txHoldWrite, rxHoldRead, noAcknowledgeFlag, transmitReadyFlag, receiveReadyFlag, irq, busy;
  logic serialDataLineOut, serialDataLineOe, serialClockLineOut, serialClockLineOe, slvPull, slvAck;
  wire logic serialDataLineIn = !((serialDataLineOe && !serialDataLineOut) || slvPull);
  wire logic serialClockLineIn = !(serialClockLineOe && !serialClockLineOut);
  int fail_count, n_checks, cyc, goal;
  twm_master dut (.*);
  twm_slave_model slv (.sda(serialDataLineIn), .scl(serialClockLineIn), .ackAddr(slvAck),
    .rdData(8'h96), .sdaPullLow(slvPull));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Fifteen bytes of some 4500 cycles each fit well inside this ceiling.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      final_report();
    end
  end
  // ==========================================================
  // Tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic pulse(input logic w, input logic s, input logic p, input logic r, input logic [7:0] d);
    @(posedge clk);
    txHoldWrite <= w;
    startCmd <= s;
    stopCmd <= p;
    rxHoldRead <= r;
    txHoldWrData <= d;
    @(posedge clk);
    {txHoldWrite, startCmd, stopCmd, rxHoldRead} <= 4'h0;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = busy;
      1: pick = transmitReadyFlag;
      2: pick = receiveReadyFlag;
      default: pick = logic'(slv.nBytes >= goal);
    endcase
  endfunction
  task automatic wait_sig(input int sel, input logic lvl);
    int i;
    i = 0;
    repeat (3) @(negedge clk);
    while (pick(sel) !== lvl && i < 30000) begin
      @(negedge clk);
      i++;
    end
    chk(8'(i < 30000), 8'h01, "wait limit");
  endtask
  task automatic expect_log(input logic [7:0] exp[$]);
    foreach (exp[k]) chk(slv.rxLog.pop_front(), exp[k], "byte on wire");
    chk(8'(slv.rxLog.size()), 8'h00, "extra bytes");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {sys_rst, masterEnableCmd, slaveDisableCmd, startCmd, stopCmd, readDirectionBit} = 6'h20;
    {txHoldWrite, rxHoldRead, txHoldWrData, intEnable, slvAck} = {10'h000, 3'h0, 1'b1};
    {targetDeviceAddress, internalAddressSize, internalAddressValue} = '0;
    {clockPrescaleField, clockLowDivider, clockHighDivider} = '0;
    {fail_count, n_checks, cyc, goal} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk({busy, irq, noAcknowledgeFlag, receiveReadyFlag, transmitReadyFlag, serialDataLineOe,
      serialClockLineOe, 1'b0}, 8'h08, "reset state");
    pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h11);
    repeat (4) @(negedge clk);
    chk({6'h00, busy, transmitReadyFlag}, 8'h01, "refused before enable");
    @(posedge clk);
    {masterEnableCmd, slaveDisableCmd, targetDeviceAddress} <= {2'b11, 7'h52};
    {internalAddressSize, internalAddressValue, intEnable} <= {2'h3, 24'h123C81, 3'h2};
    pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'hC3);
    @(negedge clk);
    chk(8'(transmitReadyFlag), 8'h00, "transmit ready clear");
    wait_sig(1, 1'b1);
    pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h5A);
    goal = 6;
    wait_sig(3, 1'b1);
    repeat (300) @(negedge clk);
    chk({serialClockLineOe, irq, 6'(slv.nStop)}, 8'hC0, "clock stretched");
    pulse(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    wait_sig(0, 1'b0);
    expect_log('{8'hA4, 8'h12, 8'h3C, 8'h81, 8'hC3, 8'h5A});
    chk({4'(slv.nStart), 4'(slv.nStop)}, 8'h11, "start stop count");
    @(posedge clk);
    {readDirectionBit, internalAddressSize, internalAddressValue, intEnable} <=
      {1'b1, 2'h2, 24'h007E01, 3'h4};
    pulse(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    wait_sig(0, 1'b0);
    expect_log('{8'hA4, 8'h7E, 8'h01, 8'hA5});
    chk(rxHoldData, 8'h96, "read data");
    chk({4'(slv.nMAck), 4'(slv.nMNack)}, 8'h01, "last byte not acknowledged");
    chk({receiveReadyFlag, irq, 6'(slv.nStart)}, 8'hC3, "receive ready");
    pulse(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    repeat (3) @(negedge clk);
    chk({6'h00, receiveReadyFlag, irq}, 8'h00, "receive ready cleared");
    @(posedge clk);
    internalAddressSize <= 2'h0;
    pulse(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    wait_sig(2, 1'b1);
    chk(rxHoldData, 8'h96, "first read byte");
    pulse(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    goal = 13;
    wait_sig(3, 1'b1);
    pulse(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    wait_sig(0, 1'b0);
    chk(rxHoldData, 8'h96, "second read byte");
    expect_log('{8'hA5});
    chk({4'(slv.nMAck), 4'(slv.nMNack)}, 8'h12, "ack all but last");
    pulse(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    @(posedge clk);
    {readDirectionBit, internalAddressSize, intEnable, slvAck, targetDeviceAddress} <=
      {1'b0, 2'h1, 3'h1, 1'b0, 7'h79};
    pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h11);
    wait_sig(0, 1'b0);
    expect_log('{8'hF2});
    chk({noAcknowledgeFlag, irq, 6'h00}, 8'hC0, "no acknowledge flag");
    chk({4'(slv.nStart), 4'(slv.nStop)}, 8'h54, "stop after refusal");
    final_report();
  end
endmodule
